// ---- hdl/nms_pkg.sv ----
// Constants, register map and carrier types of the module status block.
// Assumes a 40 MHz APB clock; the status carrier comes from the network module.
package nms_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_IO_WORDS = 8'h04;
	localparam logic [7:0] ADDR_FIRST_MAP = 8'h08;
	localparam logic [7:0] ADDR_LAST_MAP = 8'h0c;
	localparam logic [7:0] ADDR_IP = 8'h10;
	localparam logic [7:0] ADDR_RATE = 8'h14;
	localparam logic [7:0] ADDR_TMO = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1c;
	localparam logic [7:0] ADDR_INST = 8'h20;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_BYTE_ORDER_BIT = 0;
	localparam int CTRL_RESTART_BIT = 1;
	localparam int TMO_PROC_LSB = 16;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] IO_WORDS_RST = 16'h0000;
	localparam logic [15:0] MAP_RST = 16'h0000;
	localparam logic [31:0] IP_RST = 32'h0000_0000;
	localparam logic [1:0] RATE_RST = 2'h0;
	localparam logic [15:0] CONN_TMO_RST = 16'h03e8;
	localparam logic [15:0] PROC_TMO_RST = 16'h03e8;

	// ----------------------------------------
	// Cyclic exchange instances
	// ----------------------------------------
	localparam logic [15:0] IN_INSTANCE = 16'h0064;
	localparam logic [15:0] OUT_INSTANCE = 16'h0096;

	// ----------------------------------------
	// Indicator codes {red, green}
	// ----------------------------------------
	localparam logic [1:0] LED_OFF = 2'h0;
	localparam logic [1:0] LED_GREEN = 2'h1;
	localparam logic [1:0] LED_RED = 2'h2;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_KHZ = 40000;
	localparam int TICK_MS = 1;
	localparam int MS_CYCLES = TICK_MS * CLK_KHZ;
	localparam int FLASH_HALF_MS = 250;
	localparam int TEST_STEPS = 4;

	typedef enum logic [1:0] {ST_RECOG, ST_DIAG, ST_RUN, ST_SERIOUS} nms_state_type;

	typedef struct packed {
		logic present;
		logic [7:0] ident;
		logic selftest;
		logic serious_fault;
		logic recov_fault;
		logic ip_conflict;
		logic ip_assigned;
		logic major_fault;
		logic link_up;
		logic link_activity;
		logic conn_active;
	} nms_stat_type;

	typedef struct packed {
		logic [15:0] io_words;
		logic [15:0] first_map;
		logic [15:0] last_map;
		logic [31:0] ip;
		logic [1:0] rate;
	} nms_cfg_type;

endpackage : nms_pkg

// ---- hdl/nms_timebase.sv ----
// Millisecond tick and common flash phase for the indicators.
// Assumes one free-running clock; counts are shortened by parameter in simulation.
`timescale 1ns/1ps
module nms_timebase #(
	parameter int MS_CYCLES = nms_pkg::MS_CYCLES,
	parameter int FLASH_HALF_MS = nms_pkg::FLASH_HALF_MS
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	output logic ms_tick, // One-cycle pulse per ms
	output logic flash_tick, // Pulse when phase flips
	output logic flash_on // Flash phase level
);
	localparam int CW = $clog2(MS_CYCLES + 1);
	localparam int FW = $clog2(FLASH_HALF_MS + 1);

	if (MS_CYCLES < 2 || FLASH_HALF_MS < 1) begin : g_chk
		$error("nms_timebase: counts too small");
	end

	logic [CW-1:0] cyc_ff;
	logic [FW-1:0] ms_ff;
	wire cyc_end = cyc_ff == CW'(MS_CYCLES - 1);
	wire half_end = cyc_end && (ms_ff == FW'(FLASH_HALF_MS - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_ff <= '0;
			ms_ff <= '0;
			ms_tick <= 1'b0;
			flash_tick <= 1'b0;
			flash_on <= 1'b0;
		end else begin
			cyc_ff <= cyc_end ? '0 : cyc_ff + 1'b1;
			if (cyc_end) begin
				ms_ff <= half_end ? '0 : ms_ff + 1'b1;
			end
			ms_tick <= cyc_end;
			flash_tick <= half_end;
			if (half_end) begin
				flash_on <= ~flash_on;
			end
		end
	end

endmodule : nms_timebase

// ---- hdl/nms_status.sv ----
// Status indicators and configuration registers of the network module.
// Assumes an APB master on pclk and asynchronous status levels from the module.
//
// What this block does
// - Recognition runs indicator test sequence, then module indicator steady green.
// - Fitted module detected automatically; identity readable in status register.
// - Word count sets exchange; config complete only with nonzero map words.
// - Address, rate and I/O config apply only after restart.
// - Cyclic exchange uses input instance 100 and output instance 150.
// - Network indicator green only with correct config and live exchange.
// - Serious fault holds module indicator red until reinitialised.
// - Recoverable fault or IP conflict flashes module red, else green.
// - Self-diagnosis flashes both indicators alternately green and red.
// - Network indicator dark while no IP address assigned.
// - Network green when process active or idle, flashing while waiting.
// - Major fault or IP conflict holds network red until reinitialised.
// - Communication timeout flashes network indicator red.
// - Link indicator dark without physical link.
// - Link indicator green with link up but no exchange.
// - Link indicator flashes green while data is exchanged.
// - Separate connection timeout and process timeout settings.
// - Byte order setting swaps bytes within each 16-bit word.
// - Writes to read-only words ignored; unused addresses read zero.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module nms_status #(
	parameter int MS_CYCLES = nms_pkg::MS_CYCLES,
	parameter int FLASH_HALF_MS = nms_pkg::FLASH_HALF_MS
) (
	input wire logic pclk, // APB clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, always low
	input wire nms_pkg::nms_stat_type mod_stat, // Module status, async
	input wire logic [15:0] io_word_in, // Exchanged word, same clock
	output logic [15:0] io_word_out, // Word in selected byte order
	output logic [1:0] module_state_led, // {red, green}
	output logic [1:0] network_state_led, // {red, green}
	output logic link_led // Green link indicator
);
	// ----------------------------------------
	// Input synchroniser
	// ----------------------------------------
	nms_pkg::nms_stat_type s1_ff;
	nms_pkg::nms_stat_type st_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_ff <= '0;
			st_ff <= '0;
		end else begin
			s1_ff <= mod_stat;
			st_ff <= s1_ff;
		end
	end

	// ----------------------------------------
	// Timebase
	// ----------------------------------------
	logic ms_tick;
	logic flash_tick;
	logic flash_on;

	nms_timebase #(
		.MS_CYCLES(MS_CYCLES),
		.FLASH_HALF_MS(FLASH_HALF_MS)
	) u_tb (
		.pclk(pclk),
		.presetn(presetn),
		.ms_tick(ms_tick),
		.flash_tick(flash_tick),
		.flash_on(flash_on)
	);

	function automatic logic [15:0] swap16(input logic [15:0] w);
		swap16 = {w[7:0], w[15:8]};
	endfunction : swap16

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	nms_pkg::nms_cfg_type stg_ff;
	nms_pkg::nms_cfg_type run_ff;
	logic byte_order_ff;
	logic restart_ff;
	logic boot_ff;
	logic [15:0] conn_tmo_ff;
	logic [15:0] proc_tmo_ff;
	logic [7:0] ident_ff;
	logic present_ff;
	nms_pkg::nms_state_type state_ff;
	logic [1:0] step_ff;
	logic net_fault_ff;
	logic [15:0] idle_ff;

	wire setup = psel && !penable;
	wire wr_en = psel && penable && pready && pwrite;
	wire sel_ctrl = paddr == nms_pkg::ADDR_CTRL;
	wire sel_words = paddr == nms_pkg::ADDR_IO_WORDS;
	wire sel_first = paddr == nms_pkg::ADDR_FIRST_MAP;
	wire sel_last = paddr == nms_pkg::ADDR_LAST_MAP;
	wire sel_ip = paddr == nms_pkg::ADDR_IP;
	wire sel_rate = paddr == nms_pkg::ADDR_RATE;
	wire sel_tmo = paddr == nms_pkg::ADDR_TMO;
	wire sel_stat = paddr == nms_pkg::ADDR_STATUS;
	wire sel_inst = paddr == nms_pkg::ADDR_INST;
	wire apply = boot_ff || restart_ff;
	wire cfg_ok = (run_ff.io_words != 16'h0000) && (run_ff.first_map != 16'h0000)
		&& (run_ff.last_map != 16'h0000);

	wire [31:0] stat_word = {8'h00, run_ff.io_words[7:0], 2'h0, state_ff, cfg_ok,
		present_ff, ident_ff, byte_order_ff, 1'b0};
	wire [31:0] rd_mux =
		sel_ctrl ? {30'h0, 1'b0, byte_order_ff} :
		sel_words ? {16'h0, stg_ff.io_words} :
		sel_first ? {16'h0, stg_ff.first_map} :
		sel_last ? {16'h0, stg_ff.last_map} :
		sel_ip ? stg_ff.ip :
		sel_rate ? {30'h0, stg_ff.rate} :
		sel_tmo ? {proc_tmo_ff, conn_tmo_ff} :
		sel_stat ? stat_word :
		sel_inst ? {nms_pkg::OUT_INSTANCE, nms_pkg::IN_INSTANCE} :
		32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup && !pwrite) begin
				prdata <= rd_mux;
			end
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	localparam int TMO_HI = nms_pkg::TMO_PROC_LSB + 15;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stg_ff <= {nms_pkg::IO_WORDS_RST, nms_pkg::MAP_RST, nms_pkg::MAP_RST,
				nms_pkg::IP_RST, nms_pkg::RATE_RST};
			byte_order_ff <= 1'b0;
			conn_tmo_ff <= nms_pkg::CONN_TMO_RST;
			proc_tmo_ff <= nms_pkg::PROC_TMO_RST;
			restart_ff <= 1'b0;
		end else begin
			restart_ff <= wr_en && sel_ctrl && pwdata[nms_pkg::CTRL_RESTART_BIT];
			if (wr_en && sel_ctrl) begin
				byte_order_ff <= pwdata[nms_pkg::CTRL_BYTE_ORDER_BIT];
			end
			if (wr_en && sel_words) begin
				stg_ff.io_words <= pwdata[15:0];
			end
			if (wr_en && sel_first) begin
				stg_ff.first_map <= pwdata[15:0];
			end
			if (wr_en && sel_last) begin
				stg_ff.last_map <= pwdata[15:0];
			end
			if (wr_en && sel_ip) begin
				stg_ff.ip <= pwdata;
			end
			if (wr_en && sel_rate) begin
				stg_ff.rate <= pwdata[1:0];
			end
			if (wr_en && sel_tmo) begin
				conn_tmo_ff <= pwdata[15:0];
				proc_tmo_ff <= pwdata[TMO_HI:nms_pkg::TMO_PROC_LSB];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_ff <= '0;
			boot_ff <= 1'b1;
			ident_ff <= 8'h00;
			present_ff <= 1'b0;
		end else begin
			boot_ff <= 1'b0;
			if (apply) begin
				run_ff <= stg_ff;
			end
			present_ff <= st_ff.present;
			ident_ff <= st_ff.present ? st_ff.ident : 8'h00;
		end
	end

	// ----------------------------------------
	// Module state machine
	// ----------------------------------------
	nms_pkg::nms_state_type nxt_state;
	logic [1:0] nxt_step;
	wire test_end = flash_tick && (step_ff == 2'(nms_pkg::TEST_STEPS - 1));

	always_comb begin
		nxt_state = state_ff;
		nxt_step = step_ff;
		case (state_ff)
			nms_pkg::ST_RECOG: begin
				if (flash_tick) begin
					nxt_step = step_ff + 2'h1;
				end
				if (test_end) begin
					nxt_state = nms_pkg::ST_DIAG;
				end
			end
			nms_pkg::ST_DIAG: begin
				if (st_ff.serious_fault) begin
					nxt_state = nms_pkg::ST_SERIOUS;
				end else if (!st_ff.selftest) begin
					nxt_state = nms_pkg::ST_RUN;
				end
			end
			nms_pkg::ST_RUN: begin
				if (st_ff.serious_fault) begin
					nxt_state = nms_pkg::ST_SERIOUS;
				end
			end
			nms_pkg::ST_SERIOUS: nxt_state = nms_pkg::ST_SERIOUS;
			default: nxt_state = nms_pkg::ST_RECOG;
		endcase
		if (restart_ff) begin
			nxt_state = nms_pkg::ST_RECOG;
			nxt_step = 2'h0;
		end
	end

	wire in_run = (state_ff == nms_pkg::ST_RUN) || (state_ff == nms_pkg::ST_SERIOUS);
	wire net_set = in_run && (st_ff.major_fault || st_ff.ip_conflict);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= nms_pkg::ST_RECOG;
			step_ff <= 2'h0;
			net_fault_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			step_ff <= nxt_step;
			net_fault_ff <= net_set || (net_fault_ff && !restart_ff);
		end
	end

	// ----------------------------------------
	// Exchange supervision
	// ----------------------------------------
	wire idle_clr = st_ff.link_activity || !st_ff.conn_active;
	wire comm_err = st_ff.conn_active && (proc_tmo_ff != 16'h0000)
		&& (idle_ff >= proc_tmo_ff);
	wire conn_lost = st_ff.conn_active && (conn_tmo_ff != 16'h0000)
		&& (idle_ff >= conn_tmo_ff);
	wire exch = cfg_ok && st_ff.conn_active && !conn_lost && !comm_err;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_ff <= 16'h0000;
		end else if (idle_clr) begin
			idle_ff <= 16'h0000;
		end else if (ms_tick && (idle_ff != 16'hffff)) begin
			idle_ff <= idle_ff + 16'h0001;
		end
	end

	// ----------------------------------------
	// Indicator selection
	// ----------------------------------------
	wire [1:0] flash_g = flash_on ? nms_pkg::LED_GREEN : nms_pkg::LED_OFF;
	wire [1:0] flash_r = flash_on ? nms_pkg::LED_RED : nms_pkg::LED_OFF;
	wire [1:0] alt_a = flash_on ? nms_pkg::LED_GREEN : nms_pkg::LED_RED;
	wire [1:0] alt_b = flash_on ? nms_pkg::LED_RED : nms_pkg::LED_GREEN;
	wire [1:0] test_mod = (step_ff == 2'h0) ? nms_pkg::LED_GREEN :
		(step_ff == 2'h1) ? nms_pkg::LED_RED : nms_pkg::LED_OFF;
	wire [1:0] test_net = (step_ff == 2'h2) ? nms_pkg::LED_GREEN :
		(step_ff == 2'h3) ? nms_pkg::LED_RED : nms_pkg::LED_OFF;
	wire [1:0] run_mod = (st_ff.recov_fault || st_ff.ip_conflict) ? flash_r :
		nms_pkg::LED_GREEN;
	wire [1:0] run_net =
		net_fault_ff ? nms_pkg::LED_RED :
		!st_ff.ip_assigned ? nms_pkg::LED_OFF :
		comm_err ? flash_r :
		exch ? nms_pkg::LED_GREEN : flash_g;
	wire [1:0] nxt_mod =
		(state_ff == nms_pkg::ST_RECOG) ? test_mod :
		(state_ff == nms_pkg::ST_DIAG) ? alt_a :
		(state_ff == nms_pkg::ST_SERIOUS) ? nms_pkg::LED_RED : run_mod;
	wire [1:0] nxt_net =
		(state_ff == nms_pkg::ST_RECOG) ? test_net :
		(state_ff == nms_pkg::ST_DIAG) ? alt_b : run_net;
	wire nxt_link = !st_ff.link_up ? 1'b0 :
		exch ? flash_on : 1'b1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			module_state_led <= nms_pkg::LED_OFF;
			network_state_led <= nms_pkg::LED_OFF;
			link_led <= 1'b0;
			io_word_out <= 16'h0000;
		end else begin
			module_state_led <= nxt_mod;
			network_state_led <= nxt_net;
			link_led <= nxt_link;
			io_word_out <= byte_order_ff ? swap16(io_word_in) : io_word_in;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_recog_green;
		(state_ff == nms_pkg::ST_RECOG && step_ff == 2'h0 && !boot_ff)[*2]
			|-> module_state_led == nms_pkg::LED_GREEN;
	endproperty
	a_recog_green: assert property (p_recog_green) else $error("test step 0 not green");

	property p_ident;
		st_ff.present |=> ident_ff == $past(st_ff.ident);
	endproperty
	a_ident: assert property (p_ident) else $error("identity not captured");

	property p_run_stable;
		!apply |=> $stable(run_ff);
	endproperty
	a_run_stable: assert property (p_run_stable) else $error("running config changed");

	property p_net_green;
		network_state_led == nms_pkg::LED_GREEN && $past(state_ff) == nms_pkg::ST_RUN
			&& !$past(flash_on) |-> $past(exch);
	endproperty
	a_net_green: assert property (p_net_green) else $error("green without exchange");

	property p_serious;
		state_ff == nms_pkg::ST_SERIOUS && !restart_ff
			|=> state_ff == nms_pkg::ST_SERIOUS ##0 module_state_led == nms_pkg::LED_RED;
	endproperty
	a_serious: assert property (p_serious) else $error("serious fault not held red");

	property p_diag_alt;
		state_ff == nms_pkg::ST_DIAG |=> module_state_led != network_state_led;
	endproperty
	a_diag_alt: assert property (p_diag_alt) else $error("diag not alternating");

	property p_no_ip;
		state_ff == nms_pkg::ST_RUN && !net_fault_ff && !st_ff.ip_assigned
			|=> network_state_led == nms_pkg::LED_OFF;
	endproperty
	a_no_ip: assert property (p_no_ip) else $error("net lit without address");

	property p_link;
		!st_ff.link_up |=> !link_led;
	endproperty
	a_link: assert property (p_link) else $error("link lit without link");

	property p_link_green;
		st_ff.link_up && !exch |=> link_led;
	endproperty
	a_link_green: assert property (p_link_green) else $error("link not steady");

	property p_swap;
		1'b1 |=> io_word_out == ($past(byte_order_ff) ? swap16($past(io_word_in))
			: $past(io_word_in));
	endproperty
	a_swap: assert property (p_swap) else $error("byte order wrong");

	property p_unmapped;
		setup && !pwrite && paddr > nms_pkg::ADDR_INST |=> prdata == 32'h0000_0000 ##0 pready;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	c_run: cover property (state_ff == nms_pkg::ST_DIAG ##1 state_ff == nms_pkg::ST_RUN);
	c_exch: cover property (network_state_led == nms_pkg::LED_GREEN && link_led);
	c_serious: cover property (state_ff == nms_pkg::ST_SERIOUS);
	c_tmo: cover property (comm_err);

endmodule : nms_status

// ---- sim/nms_master_model.sv ----
// Network master model: holds a connection and sends cyclic telegrams.
// Assumes the bench sets online and talking just after pclk edges.
`timescale 1ns/1ps
module nms_master_model (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic online, // Connection wanted
	input wire logic talking, // Cyclic traffic wanted
	output logic conn_active, // Connection held
	output logic link_activity // Telegram pulses
);
	logic [1:0] cnt_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 2'h0;
			conn_active <= 1'b0;
			link_activity <= 1'b0;
		end else begin
			cnt_ff <= (cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
			conn_active <= online;
			link_activity <= talking && cnt_ff == 2'h0;
		end
	end
endmodule : nms_master_model

// ---- sim/testbench.sv ----
// Bench of the module status block: APB master, status stimulus, indicator checks.
// Assumes shortened timing: 4 cycles per ms, 2 ms flash half period.
`timescale 1ns/1ps
module testbench;
	localparam logic [7:0] ID = 8'h5a; // Arbitrary identity value
	localparam logic [1:0] G = nms_pkg::LED_GREEN;
	localparam logic [1:0] R = nms_pkg::LED_RED;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, link_led;
	logic online, talking, m_conn, m_act;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_val, seed;
	logic [15:0] io_word_in, io_word_out;
	logic [1:0] module_state_led, network_state_led;
	nms_pkg::nms_stat_type st, ms;
	logic [31:0] exp_q[$];
	int fails, comparisons, cm[4], cn[4], cl[2], gr, rg;

	nms_status #(.MS_CYCLES(4), .FLASH_HALF_MS(2)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .mod_stat(ms),
		.io_word_in(io_word_in), .io_word_out(io_word_out),
		.module_state_led(module_state_led), .network_state_led(network_state_led),
		.link_led(link_led));
	nms_master_model master (.pclk(pclk), .presetn(presetn), .online(online),
		.talking(talking), .conn_active(m_conn), .link_activity(m_act));

	always_comb begin
		ms = st;
		ms.conn_active = m_conn;
		ms.link_activity = m_act;
	end

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	function automatic logic [31:0] sx(input logic [7:0] io, input logic [1:0] s, input logic c);
		return {8'h00, io, 2'h0, s, c, 1'b1, ID, 2'h0};
	endfunction : sx

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (!pready && n < 16);
		rd_val = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fails++;
			stop_test();
		end
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic wst(input logic [1:0] s);
		for (int i = 0; i < 60; i++) begin
			apb(1'b0, nms_pkg::ADDR_STATUS, 32'h0);
			if (rd_val[13:12] === s) break;
		end
		if (rd_val[13:12] !== s) begin
			fails++;
			stop_test();
		end
	endtask : wst

	task automatic obs(input int n);
		cm = '{default: 0};
		cn = '{default: 0};
		cl = '{default: 0};
		gr = 0;
		rg = 0;
		repeat (n) begin
			@(posedge pclk);
			#1;
			cm[module_state_led]++;
			cn[network_state_led]++;
			cl[link_led]++;
			if (module_state_led == G && network_state_led == R) gr++;
			if (module_state_led == R && network_state_led == G) rg++;
		end
	endtask : obs

	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			check(pslverr, 32'h0);
		end
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			check(prdata, exp_q.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		stop_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 32'h0001_25dd;
		fails = 0;
		comparisons = 0;
		{presetn, psel, penable, pwrite, online, talking} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		io_word_in = 16'h0;
		st = '0;
		st.present = 1'b1;
		st.ident = ID;
		st.ip_assigned = 1'b1;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		obs(40);
		check(cm[R] > 0 && cn[G] > 0, 1);
		wst(2'h2);
		obs(8);
		check(cm[G], 8);
		rd(nms_pkg::ADDR_STATUS, sx(8'h00, 2'h2, 1'b0));
		rd(8'h40, 32'h0);
		apb(1'b1, nms_pkg::ADDR_INST, 32'hffff_ffff);
		rd(nms_pkg::ADDR_INST, {16'h0096, 16'h0064});
		rd(nms_pkg::ADDR_TMO, 32'h03e8_03e8);
		seed = xs(seed);
		apb(1'b1, nms_pkg::ADDR_IP, seed);
		rd(nms_pkg::ADDR_IP, seed);
		apb(1'b1, nms_pkg::ADDR_IO_WORDS, 32'h3);
		apb(1'b1, nms_pkg::ADDR_FIRST_MAP, 32'h1);
		apb(1'b1, nms_pkg::ADDR_LAST_MAP, 32'h2);
		rd(nms_pkg::ADDR_IO_WORDS, 32'h3);
		rd(nms_pkg::ADDR_STATUS, sx(8'h00, 2'h2, 1'b0));
		apb(1'b1, nms_pkg::ADDR_CTRL, 32'h2);
		wst(2'h2);
		rd(nms_pkg::ADDR_STATUS, sx(8'h03, 2'h2, 1'b1));
		st.ip_assigned <= 1'b0;
		repeat (5) @(posedge pclk);
		obs(20);
		check(cn[0], 20);
		check(cl[0], 20);
		st.ip_assigned <= 1'b1;
		st.link_up <= 1'b1;
		repeat (5) @(posedge pclk);
		obs(32);
		check(cn[G] > 0 && cn[0] > 0, 1);
		check(cl[1], 32);
		online <= 1'b1;
		talking <= 1'b1;
		repeat (8) @(posedge pclk);
		obs(32);
		check(cn[G], 32);
		check(cl[1] > 0 && cl[0] > 0, 1);
		apb(1'b1, nms_pkg::ADDR_TMO, {16'h0002, 16'h03e8});
		talking <= 1'b0;
		repeat (30) @(posedge pclk);
		obs(32);
		check(cn[R] > 0 && cn[0] > 0, 1);
		talking <= 1'b1;
		repeat (8) @(posedge pclk);
		for (int b = 0; b < 2; b++) begin
			apb(1'b1, nms_pkg::ADDR_CTRL, b);
			repeat (8) begin
				seed = xs(seed);
				@(posedge pclk);
				io_word_in <= seed[15:0];
				@(posedge pclk);
				#1;
				check(io_word_out, b ? {seed[7:0], seed[15:8]} : seed[15:0]);
			end
		end
		apb(1'b1, nms_pkg::ADDR_CTRL, 32'h0);
		st.ip_conflict <= 1'b1;
		repeat (5) @(posedge pclk);
		obs(32);
		check(cm[R] > 0 && cm[0] > 0, 1);
		check(cn[R], 32);
		st.ip_conflict <= 1'b0;
		repeat (5) @(posedge pclk);
		obs(20);
		check(cm[G], 20);
		check(cn[R], 20);
		apb(1'b1, nms_pkg::ADDR_CTRL, 32'h2);
		wst(2'h2);
		obs(8);
		check(cn[R], 0);
		st.recov_fault <= 1'b1;
		st.major_fault <= 1'b1;
		repeat (5) @(posedge pclk);
		obs(32);
		check(cm[R] > 0 && cm[0] > 0, 1);
		check(cn[R], 32);
		st.recov_fault <= 1'b0;
		st.major_fault <= 1'b0;
		repeat (5) @(posedge pclk);
		obs(8);
		check(cm[G], 8);
		check(cn[R], 8);
		st.selftest <= 1'b1;
		apb(1'b1, nms_pkg::ADDR_CTRL, 32'h2);
		wst(2'h1);
		obs(32);
		check(gr > 0 && rg > 0, 1);
		st.selftest <= 1'b0;
		wst(2'h2);
		st.serious_fault <= 1'b1;
		repeat (5) @(posedge pclk);
		st.serious_fault <= 1'b0;
		repeat (5) @(posedge pclk);
		obs(20);
		check(cm[R], 20);
		rd(nms_pkg::ADDR_STATUS, sx(8'h03, 2'h3, 1'b1));
		stop_test();
	end
endmodule : testbench
